/* design/scal_loader.sv */
// secure configuration loader: decrypt, authenticate, commit, protect
`timescale 1ns/10ps
`default_nettype none

module scal_loader #(
  parameter bit           PROC_VARIANT = 1'b0,
  // arbitrary preset key for the processor variant
  parameter logic [127:0] PRESET_KEY   = 128'h0123456789abcdef0f1e2d3c4b5a6978
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [31:0]  reg_rdata,
  input  wire logic         stream_valid,
  input  wire logic [127:0] stream_data,
  input  wire logic         stream_last,
  output logic              stream_ready,
  output logic              aes_start,
  output logic      [127:0] aes_block,
  output logic      [127:0] aes_key,
  input  wire logic         aes_done,
  input  wire logic [127:0] aes_result,
  input  wire logic [3:0]   cfg_addr,
  output logic      [127:0] cfg_word,
  output logic              design_run,
  output logic              irq
);
  localparam logic [4:0] DEPTH_L = 5'd16;

  scal_pkg::scal_state_e state;
  scal_pkg::scal_op_e    op;

  logic [127:0] stage_mem [scal_pkg::DEPTH];
  logic [127:0] cfg_mem   [scal_pkg::DEPTH];
  logic [31:0]  urom      [scal_pkg::UROM_N];

  logic [127:0] key_store;
  logic [127:0] key_new;
  logic [31:0]  pass_store;
  logic [31:0]  pass_new;
  logic [31:0]  pass_in;
  logic [4:0]   sec;
  logic [4:0]   sec_new;
  logic [1:0]   urom_a;
  logic [31:0]  urom_wd;
  logic [3:0]   irq_st;
  logic [3:0]   irq_msk;
  logic [3:0]   irq_set;
  logic [4:0]   blk_cnt;
  logic [4:0]   prog_idx;
  logic [127:0] mac_acc;
  logic [127:0] cur_blk;
  logic         cur_last;
  logic         overflow;
  logic         mismatch;
  logic         auth_done;
  logic         auth_pass;
  logic         verify_ok;
  logic         plain_mode;
  logic         unlocked;
  logic         can_prog;
  logic         can_verify;
  logic         can_rom_rd;
  logic         can_rom_wr;
  logic         can_sec;
  logic         wr_ctrl;
  logic         mac_ok;

  // running authentication step; chained so order and content both count
  function automatic logic [127:0] mac_step(input logic [127:0] acc,
                                            input logic [127:0] blk);
    logic [127:0] t;
    t = acc ^ blk;
    mac_step = {t[126:0], t[127]} ^ {t[63:0], t[127:64]};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // access rights
  assign unlocked   = !sec[scal_pkg::SEC_PASS] || (pass_in == pass_store);
  assign can_prog   = unlocked && !sec[scal_pkg::SEC_LOCK]
                      && !sec[scal_pkg::SEC_WPROT];
  assign can_verify = !sec[scal_pkg::SEC_LOCK]
                      && (unlocked || sec[scal_pkg::SEC_WPROT]);
  assign can_rom_rd = !sec[scal_pkg::SEC_LOCK]
                      && (unlocked || sec[scal_pkg::SEC_WPROT]);
  // processor variant refuses all register writes to the user ROM
  assign can_rom_wr = unlocked && !sec[scal_pkg::SEC_LOCK]
                      && !PROC_VARIANT;
  assign can_sec    = unlocked && !sec[scal_pkg::SEC_PERM]
                      && !sec[scal_pkg::SEC_LOCK];
  // with AES off the decryptor is bypassed (pass-key-only or no protection)
  assign plain_mode = !sec[scal_pkg::SEC_AES] && !PROC_VARIANT;

  assign wr_ctrl    = reg_wr && hit(reg_addr, scal_pkg::REG_CTRL);
  assign aes_key    = key_store;
  assign aes_block  = cur_blk;
  assign mac_ok     = (mac_acc == cur_blk);
  assign design_run = (state != scal_pkg::ST_ERASE)
                      && (state != scal_pkg::ST_PROG);
  assign stream_ready = (state == scal_pkg::ST_LOAD);
  assign irq        = |(irq_st & irq_msk);

  // sequencing of a load
  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= scal_pkg::ST_IDLE;
      op        <= scal_pkg::OP_PROG;
      aes_start <= 1'b0;
      cur_blk   <= '0;
      cur_last  <= 1'b0;
      blk_cnt   <= '0;
      prog_idx  <= '0;
      mac_acc   <= scal_pkg::MAC_IV;
      overflow  <= 1'b0;
      mismatch  <= 1'b0;
      auth_done <= 1'b0;
      auth_pass <= 1'b0;
      verify_ok <= 1'b0;
    end else begin
      aes_start <= 1'b0;
      case (state)
        scal_pkg::ST_IDLE: begin
          if (wr_ctrl && reg_wdata[scal_pkg::CTL_PROG] && can_prog) begin
            state     <= scal_pkg::ST_LOAD;
            op        <= scal_pkg::OP_PROG;
            blk_cnt   <= '0;
            mac_acc   <= scal_pkg::MAC_IV;
            overflow  <= 1'b0;
            mismatch  <= 1'b0;
            auth_done <= 1'b0;
            auth_pass <= 1'b0;
          end else if (wr_ctrl && reg_wdata[scal_pkg::CTL_VERIFY]
                       && can_verify) begin
            state     <= scal_pkg::ST_LOAD;
            op        <= scal_pkg::OP_VERIFY;
            blk_cnt   <= '0;
            mac_acc   <= scal_pkg::MAC_IV;
            overflow  <= 1'b0;
            mismatch  <= 1'b0;
            auth_done <= 1'b0;
            auth_pass <= 1'b0;
            verify_ok <= 1'b0;
          end
        end
        scal_pkg::ST_LOAD: begin
          if (wr_ctrl && reg_wdata[scal_pkg::CTL_ABORT]) begin
            state <= scal_pkg::ST_IDLE;
          end else if (stream_valid) begin
            cur_blk  <= stream_data;
            cur_last <= stream_last;
            if (plain_mode) begin
              state <= scal_pkg::ST_CHECK;
            end else begin
              aes_start <= 1'b1;
              state     <= scal_pkg::ST_DECR;
            end
          end
        end
        scal_pkg::ST_DECR: begin
          if (aes_done) begin
            cur_blk <= aes_result;
            state   <= scal_pkg::ST_CHECK;
          end
        end
        scal_pkg::ST_CHECK: begin
          if (cur_last) begin
            // final block is the tag; a wrong key garbles it and the data
            auth_done <= 1'b1;
            auth_pass <= mac_ok && !overflow;
            verify_ok <= mac_ok && !overflow && !mismatch;
            if (mac_ok && !overflow && op == scal_pkg::OP_PROG) begin
              state <= scal_pkg::ST_ERASE;
            end else begin
              state <= scal_pkg::ST_IDLE;
            end
          end else begin
            mac_acc <= mac_step(mac_acc, cur_blk);
            if (blk_cnt == DEPTH_L) begin
              overflow <= 1'b1;
            end else begin
              if (op == scal_pkg::OP_VERIFY
                  && cfg_mem[blk_cnt[3:0]] != cur_blk) begin
                mismatch <= 1'b1;
              end
              blk_cnt <= blk_cnt + 5'd1;
            end
            state <= scal_pkg::ST_LOAD;
          end
        end
        scal_pkg::ST_ERASE: begin
          prog_idx <= '0;
          state    <= scal_pkg::ST_PROG;
        end
        scal_pkg::ST_PROG: begin
          if (prog_idx + 5'd1 >= blk_cnt) begin
            state <= scal_pkg::ST_IDLE;
          end
          prog_idx <= prog_idx + 5'd1;
        end
        default: state <= scal_pkg::ST_IDLE;
      endcase
    end
  end

  // staging holds decrypted data until authentication clears it
  always_ff @(posedge clk) begin
    if (state == scal_pkg::ST_CHECK && !cur_last && op == scal_pkg::OP_PROG
        && blk_cnt != DEPTH_L) begin
      stage_mem[blk_cnt[3:0]] <= cur_blk;
    end
  end

  // configuration array: changed only by srst, erase and program
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < scal_pkg::DEPTH; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (state == scal_pkg::ST_ERASE) begin
      for (int i = 0; i < scal_pkg::DEPTH; i++) begin
        cfg_mem[i] <= '0;
      end
    end else if (state == scal_pkg::ST_PROG && prog_idx < blk_cnt) begin
      cfg_mem[prog_idx[3:0]] <= stage_mem[prog_idx[3:0]];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cfg_word <= '0;
    end else begin
      cfg_word <= cfg_mem[cfg_addr];
    end
  end

  // security settings; srst stands in for the nonvolatile power-up load
  always_ff @(posedge clk) begin
    if (srst) begin
      sec        <= PROC_VARIANT ? 5'h03 : scal_pkg::SEC_RST;
      key_store  <= PROC_VARIANT ? PRESET_KEY : '0;
      pass_store <= scal_pkg::PASS_RST;
    end else if (wr_ctrl && reg_wdata[scal_pkg::CTL_SEC] && can_sec
                 && state == scal_pkg::ST_IDLE
                 && !(sec_new[scal_pkg::SEC_AES]
                      && !sec_new[scal_pkg::SEC_PASS])) begin
      sec        <= PROC_VARIANT ? (sec_new | 5'h03) : sec_new;
      key_store  <= key_new;
      pass_store <= pass_new;
    end
  end

  // staged values written by software
  always_ff @(posedge clk) begin
    if (srst) begin
      key_new  <= '0;
      pass_new <= '0;
      pass_in  <= '0;
      sec_new  <= '0;
      urom_a   <= '0;
      urom_wd  <= '0;
    end else if (reg_wr) begin
      if (hit(reg_addr, scal_pkg::REG_PASS_IN)) begin
        pass_in <= reg_wdata;
      end
      if (hit(reg_addr, scal_pkg::REG_PASS_NW)) begin
        pass_new <= reg_wdata;
      end
      if (hit(reg_addr, scal_pkg::REG_SEC_CFG)) begin
        sec_new <= reg_wdata[scal_pkg::SEC_W-1:0];
      end
      if (hit(reg_addr, scal_pkg::REG_UROM_A)) begin
        urom_a <= reg_wdata[1:0];
      end
      if (hit(reg_addr, scal_pkg::REG_UROM_D)) begin
        urom_wd <= reg_wdata;
      end
      for (int k = 0; k < 4; k++) begin
        if (hit(reg_addr, scal_pkg::REG_KEY0 + 8'(4 * k))) begin
          key_new[32*k +: 32] <= reg_wdata;
        end
      end
    end
  end

  // user ROM
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < scal_pkg::UROM_N; i++) begin
        urom[i] <= '0;
      end
    end else if (wr_ctrl && reg_wdata[scal_pkg::CTL_UROM_WR]
                 && can_rom_wr) begin
      urom[urom_a] <= urom_wd;
    end
  end

  // interrupt events
  always_comb begin
    irq_set = '0;
    if (state == scal_pkg::ST_CHECK && cur_last) begin
      irq_set[scal_pkg::IRQ_DONE]  = 1'b1;
      irq_set[scal_pkg::IRQ_AFAIL] = !mac_ok || overflow;
      irq_set[scal_pkg::IRQ_VFAIL] = (op == scal_pkg::OP_VERIFY)
                                     && (!mac_ok || overflow || mismatch);
    end
    if (wr_ctrl) begin
      irq_set[scal_pkg::IRQ_REFUSE] =
        (reg_wdata[scal_pkg::CTL_PROG] && (!can_prog
          || state != scal_pkg::ST_IDLE))
        || (reg_wdata[scal_pkg::CTL_VERIFY] && !can_verify)
        || (reg_wdata[scal_pkg::CTL_SEC] && (!can_sec
          || (sec_new[scal_pkg::SEC_AES] && !sec_new[scal_pkg::SEC_PASS])))
        || (reg_wdata[scal_pkg::CTL_UROM_WR] && !can_rom_wr);
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_st  <= '0;
      irq_msk <= '0;
    end else begin
      if (reg_wr && hit(reg_addr, scal_pkg::REG_IRQ_ST)) begin
        irq_st <= (irq_st & ~reg_wdata[3:0]) | irq_set;
      end else begin
        irq_st <= irq_st | irq_set;
      end
      if (reg_wr && hit(reg_addr, scal_pkg::REG_IRQ_MSK)) begin
        irq_msk <= reg_wdata[3:0];
      end
    end
  end

  // read port; keys and pass values read as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          scal_pkg::REG_STATUS:
            reg_rdata <= {16'h0000, 3'b000, sec, unlocked, verify_ok,
                          auth_pass, auth_done, 1'b0, state};
          scal_pkg::REG_IRQ_ST:  reg_rdata <= {28'h0, irq_st};
          scal_pkg::REG_IRQ_MSK: reg_rdata <= {28'h0, irq_msk};
          scal_pkg::REG_SEC_CFG: reg_rdata <= {27'h0, sec};
          scal_pkg::REG_UROM_A:  reg_rdata <= {30'h0, urom_a};
          scal_pkg::REG_UROM_D:
            reg_rdata <= can_rom_rd ? urom[urom_a] : 32'h00000000;
          default: reg_rdata <= '0;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

/* shared/scal_pkg.sv */
// constants for the secure configuration loader
package scal_pkg;
  localparam int          BLK_W       = 128;
  localparam int          DEPTH       = 16;
  localparam int          IDX_W       = 5;
  localparam int          ADDR_W      = 8;
  localparam int          UROM_N      = 4;
  // register byte offsets
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_IRQ_ST  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MSK = 8'h0c;
  localparam logic [7:0]  REG_PASS_IN = 8'h10;
  localparam logic [7:0]  REG_SEC_CFG = 8'h14;
  localparam logic [7:0]  REG_PASS_NW = 8'h18;
  localparam logic [7:0]  REG_KEY0    = 8'h1c;
  localparam logic [7:0]  REG_UROM_A  = 8'h2c;
  localparam logic [7:0]  REG_UROM_D  = 8'h30;
  // control bits
  localparam int          CTL_PROG    = 0;
  localparam int          CTL_VERIFY  = 1;
  localparam int          CTL_SEC     = 2;
  localparam int          CTL_UROM_WR = 3;
  localparam int          CTL_ABORT   = 4;
  // security setting bits
  localparam int          SEC_AES     = 0;
  localparam int          SEC_PASS    = 1;
  localparam int          SEC_WPROT   = 2;
  localparam int          SEC_PERM    = 3;
  localparam int          SEC_LOCK    = 4;
  localparam int          SEC_W       = 5;
  // interrupt status bits
  localparam int          IRQ_DONE    = 0;
  localparam int          IRQ_AFAIL   = 1;
  localparam int          IRQ_REFUSE  = 2;
  localparam int          IRQ_VFAIL   = 3;
  localparam int          IRQ_W       = 4;
  // reset values
  localparam logic [4:0]  SEC_RST     = 5'h00;
  localparam logic [31:0] PASS_RST    = 32'h00000000;
  localparam logic [127:0] MAC_IV     = 128'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_DECR  = 3'b010,
    ST_CHECK = 3'b011,
    ST_ERASE = 3'b100,
    ST_PROG  = 3'b101
  } scal_state_e;

  typedef enum logic [0:0] {
    OP_PROG   = 1'b0,
    OP_VERIFY = 1'b1
  } scal_op_e;
endpackage

/* verification/scal_loader_props.sv */
// port checker for the secure configuration loader
`timescale 1ns/10ps
`default_nettype none
module scal_props (
  input wire logic         clk,
  input wire logic         srst,
  input wire logic [7:0]   reg_addr,
  input wire logic         reg_rd,
  input wire logic [31:0]  reg_rdata,
  input wire logic         stream_valid,
  input wire logic [127:0] stream_data,
  input wire logic         stream_last,
  input wire logic         stream_ready,
  input wire logic         aes_start,
  input wire logic [127:0] aes_block,
  input wire logic [3:0]   cfg_addr,
  input wire logic [127:0] cfg_word,
  input wire logic         design_run
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic tag_seen;
  // a commit needs a tag taken since the last data block
  always_ff @(posedge clk) begin
    if (srst)
      tag_seen <= 1'b0;
    else if (stream_valid && stream_ready && stream_last)
      tag_seen <= 1'b1;
    else if (stream_ready || !design_run)
      tag_seen <= 1'b0;
  end
  AST_KEY_HIDDEN: assert property (
    reg_rd && reg_addr >= 8'h1c && reg_addr <= 8'h28 |=> reg_rdata == '0)
    else $error("key word readable");
  AST_PASS_HIDDEN: assert property (
    reg_rd && (reg_addr == scal_pkg::REG_PASS_IN
    || reg_addr == scal_pkg::REG_PASS_NW) |=> reg_rdata == '0)
    else $error("pass key readable");
  AST_DECRYPT_IN: assert property (
    aes_start |-> $past(stream_valid && stream_ready)
    && aes_block == $past(stream_data))
    else $error("decrypt block not the taken block");
  AST_START_PULSE: assert property (aes_start |=> !aes_start)
    else $error("decrypt start longer than one cycle");
  AST_READY_DROP: assert property (
    stream_valid && stream_ready |=> !stream_ready)
    else $error("ready held after a take");
  AST_LOAD_LIVE: assert property (stream_ready |-> design_run)
    else $error("design stopped while loading");
  AST_COMMIT_AFTER_TAG: assert property ($fell(design_run) |-> tag_seen)
    else $error("erase without a checked tag");
  AST_COMMIT_BOUNDED: assert property (
    $fell(design_run) |-> ##[1:20] design_run)
    else $error("commit too long");
  // a commit's last write lands as design_run rises, so skip that edge
  AST_CFG_HELD: assert property (
    $stable(cfg_addr) && design_run && $past(design_run)
    |=> $stable(cfg_word))
    else $error("array changed while running");
endmodule
bind scal_loader scal_props u_props (.clk(clk), .srst(srst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .stream_valid(stream_valid), .stream_data(stream_data),
  .stream_last(stream_last), .stream_ready(stream_ready),
  .aes_start(aes_start), .aes_block(aes_block), .cfg_addr(cfg_addr),
  .cfg_word(cfg_word), .design_run(design_run));
`default_nettype wire

/* verification/scal_prog_model.sv */
// programmer model driving the loader stream port
`timescale 1ns/10ps
`default_nettype none
module scal_prog_model (
  input  wire logic   clk,
  input  wire logic   stream_ready,
  output logic        stream_valid,
  output logic [127:0] stream_data,
  output logic        stream_last
);
  initial begin
    stream_valid = 1'b0;
    stream_data = '0;
    stream_last = 1'b0;
  end
  function automatic logic [127:0] pat(input logic [31:0] s, input int i);
    return {s, s ^ 32'(i), ~s, 32'(i)};
  endfunction
  // xor stands in for the cipher; the bench decryptor undoes it
  task automatic run(input logic [127:0] key, input int n, input logic bad,
                     input logic [31:0] s, input logic enc, input int gap);
    logic [127:0] acc;
    logic [127:0] t;
    logic [127:0] d;
    int w;
    acc = '0;
    for (int i = 0; i <= n; i++) begin
      if (i < n) begin
        d = pat(s, i);
        t = acc ^ d;
        acc = {t[126:0], t[127]} ^ {t[63:0], t[127:64]};
      end else begin
        d = acc ^ {127'h0, bad};
      end
      if (enc)
        d = d ^ key;
      repeat (gap) @(posedge clk);
      stream_valid <= 1'b1;
      stream_data <= d;
      stream_last <= (i == n);
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!stream_ready && w < 200);
      stream_valid <= 1'b0;
      // released bus must not keep the last block
      stream_data <= ~d;
      stream_last <= 1'b0;
      if (!stream_ready)
        return;
      @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

/* verification/tb_secure_config_auth_loader.sv */
// self-checking bench for the secure configuration loader
`timescale 1ns/10ps
`default_nettype none
module tb_secure_config_auth_loader;
  typedef struct {
    logic        op;
    logic [127:0] key;
    int          n;
    logic        bad;
    logic [31:0] s;
    logic        ep;
    logic        ev;
  } scal_row_s;
  localparam logic [127:0] KA = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] KB = 128'h0f0e0d0c0b0a09080706050403020100;
  localparam logic [31:0]  PK = 32'hc0de5eed;
  localparam logic [31:0]  UV = 32'h5a5a1234;
  logic         clk = 1'b0;
  logic         srst = 1'b1;
  logic [7:0]   reg_addr = '0;
  logic [31:0]  reg_wdata = '0;
  logic         reg_wr = 1'b0;
  logic         reg_rd = 1'b0;
  logic [31:0]  reg_rdata;
  logic         s_valid;
  logic [127:0] s_data;
  logic         s_last;
  logic         s_ready;
  logic         aes_start;
  logic [127:0] aes_block;
  logic [127:0] aes_key;
  logic         aes_done = 1'b0;
  logic [127:0] aes_result = '0;
  logic [3:0]   cfg_addr = '0;
  logic [127:0] cfg_word;
  logic         design_run;
  logic         irq;
  logic [31:0]  pv_rdata;
  logic [127:0] pv_key;
  logic [31:0]  pv_rd = '0;
  logic [31:0]  rdv;
  logic [127:0] exp_cfg [16];
  int           err_count = 0;
  int           compares = 0;
  int           low_cnt = 0;
  scal_row_s rows [7] = '{
    '{1'b0, KA, 4, 1'b0, 32'ha1, 1'b1, 1'b0},
    '{1'b0, KB, 3, 1'b0, 32'ha2, 1'b0, 1'b0},
    '{1'b0, KA, 2, 1'b1, 32'ha3, 1'b0, 1'b0},
    '{1'b1, KA, 4, 1'b0, 32'ha1, 1'b1, 1'b1},
    '{1'b1, KA, 4, 1'b0, 32'ha4, 1'b1, 1'b0},
    '{1'b0, KA, 16, 1'b0, 32'ha5, 1'b1, 1'b0},
    '{1'b0, KA, 17, 1'b0, 32'ha6, 1'b0, 1'b0}
  };
  always #5 clk = ~clk;
  // decryptor stand-in, one cycle latency
  always @(posedge clk) begin
    aes_done <= aes_start;
    aes_result <= aes_block ^ aes_key;
  end
  always @(posedge clk) if (!srst && !design_run) low_cnt++;
  scal_loader dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .stream_valid(s_valid), .stream_data(s_data),
    .stream_last(s_last), .stream_ready(s_ready), .aes_start(aes_start),
    .aes_block(aes_block), .aes_key(aes_key), .aes_done(aes_done),
    .aes_result(aes_result), .cfg_addr(cfg_addr), .cfg_word(cfg_word),
    .design_run(design_run), .irq(irq));
  scal_prog_model prog (.clk(clk), .stream_ready(s_ready),
    .stream_valid(s_valid), .stream_data(s_data), .stream_last(s_last));
  // processor variant beside the plain one, sharing the register bus
  scal_loader #(.PROC_VARIANT(1'b1), .PRESET_KEY(KB)) dut_pv (.clk(clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(pv_rdata),
    .stream_valid(1'b0), .stream_data(128'h0), .stream_last(1'b0),
    .stream_ready(), .aes_start(), .aes_block(), .aes_key(pv_key),
    .aes_done(1'b0), .aes_result(128'h0), .cfg_addr(cfg_addr),
    .cfg_word(), .design_run(), .irq());
  task automatic chk(input string nm, input logic [127:0] e,
                     input logic [127:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
    pv_rd = pv_rdata;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d & m);
  endtask
  task automatic commit(input logic [31:0] sec);
    wr(scal_pkg::REG_SEC_CFG, sec);
    wr(scal_pkg::REG_CTRL, 32'h4);
  endtask
  task automatic do_prog(input scal_row_s r, input int gap, input logic enc);
    logic [31:0] st;
    int k;
    wr(scal_pkg::REG_IRQ_ST, 32'hf);
    wr(scal_pkg::REG_CTRL, r.op ? 32'h2 : 32'h1);
    low_cnt = 0;
    prog.run(r.key, r.n, r.bad, r.s, enc, gap);
    k = 0;
    st = '0;
    while (!(st[4] && st[2:0] == 3'h0) && k < 100) begin
      rd(scal_pkg::REG_STATUS, st);
      k++;
    end
    chk("auth_done", 1, st[4]);
    chk("auth_pass", r.ep, st[5]);
    chk("run_low", (r.ep && !r.op) ? r.n + 1 : 0, low_cnt);
    if (r.op)
      chk("verify_ok", r.ev, st[6]);
    rchk(scal_pkg::REG_IRQ_ST, 32'hb, {r.op && !r.ev, 1'b0, !r.ep, 1'b1},
         "irq_st");
    if (r.ep && !r.op)
      for (k = 0; k < 16; k++)
        exp_cfg[k] = (k < r.n) ? prog.pat(r.s, k) : '0;
    for (k = 0; k < 16; k++) begin
      cfg_addr <= 4'(k);
      @(posedge clk);
      @(negedge clk);
      chk("cfg_word", exp_cfg[k], cfg_word);
      @(posedge clk);
    end
    $display("test done op %0d blocks %0d", r.op, r.n);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rchk(scal_pkg::REG_STATUS, 32'h1f87, 32'h80, "status");
    chk("pv status", 32'h380, pv_rd & 32'h1f87);
    chk("pv key", KB, pv_key);
    wr(scal_pkg::REG_UROM_A, 32'h1);
    wr(scal_pkg::REG_UROM_D, UV);
    wr(scal_pkg::REG_CTRL, 32'h8);
    rd(scal_pkg::REG_IRQ_ST, rdv);
    chk("pv rom refused", 32'h4, pv_rd & 32'h4);
    do_prog('{1'b0, '0, 2, 1'b0, 32'h11, 1'b1, 1'b0}, 0, 1'b0);
    wr(scal_pkg::REG_IRQ_MSK, 32'h4);
    commit(32'h1);
    rchk(scal_pkg::REG_SEC_CFG, 32'h1f, 32'h0, "sec_cfg");
    chk("irq", 1, irq);
    wr(scal_pkg::REG_IRQ_MSK, 32'h0);
    chk("irq masked", 0, irq);
    wr(scal_pkg::REG_IRQ_MSK, 32'h4);
    wr(scal_pkg::REG_IRQ_ST, 32'h4);
    chk("irq cleared", 0, irq);
    for (int k = 0; k < 4; k++)
      wr(scal_pkg::REG_KEY0 + 8'(4 * k), KA[32 * k +: 32]);
    wr(scal_pkg::REG_PASS_NW, PK);
    commit(32'h3);
    rchk(scal_pkg::REG_SEC_CFG, 32'h1f, 32'h3, "sec_cfg");
    rchk(scal_pkg::REG_KEY0, 32'hffffffff, 32'h0, "key");
    rchk(scal_pkg::REG_PASS_NW, 32'hffffffff, 32'h0, "pass");
    rchk(scal_pkg::REG_STATUS, 32'h80, 32'h0, "unlocked");
    rchk(scal_pkg::REG_UROM_D, 32'hffffffff, 32'h0, "urom");
    wr(scal_pkg::REG_IRQ_ST, 32'hf);
    wr(scal_pkg::REG_CTRL, 32'h1);
    rchk(scal_pkg::REG_IRQ_ST, 32'h4, 32'h4, "refused");
    wr(scal_pkg::REG_PASS_IN, PK);
    rchk(scal_pkg::REG_PASS_IN, 32'hffffffff, 32'h0, "pass");
    foreach (rows[i])
      do_prog(rows[i], (i % 2) * 3, 1'b1);
    commit(32'hf);
    wr(scal_pkg::REG_PASS_IN, 32'h0);
    rchk(scal_pkg::REG_UROM_D, 32'hffffffff, UV, "urom");
    wr(scal_pkg::REG_IRQ_ST, 32'hf);
    wr(scal_pkg::REG_CTRL, 32'h1);
    rchk(scal_pkg::REG_IRQ_ST, 32'h4, 32'h4, "refused");
    wr(scal_pkg::REG_CTRL, 32'h2);
    rchk(scal_pkg::REG_STATUS, 32'h7, 32'h1, "state");
    wr(scal_pkg::REG_CTRL, 32'h10);
    wr(scal_pkg::REG_PASS_IN, PK);
    commit(32'h3);
    rchk(scal_pkg::REG_SEC_CFG, 32'h1f, 32'hf, "sec_cfg");
    $display("test done permanent settings");
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    wr(scal_pkg::REG_UROM_D, UV);
    wr(scal_pkg::REG_CTRL, 32'h8);
    commit(32'h10);
    rchk(scal_pkg::REG_UROM_D, 32'hffffffff, 32'h0, "urom");
    wr(scal_pkg::REG_IRQ_ST, 32'hf);
    wr(scal_pkg::REG_CTRL, 32'h2);
    rchk(scal_pkg::REG_IRQ_ST, 32'h4, 32'h4, "refused");
    commit(32'h0);
    rchk(scal_pkg::REG_SEC_CFG, 32'h1f, 32'h10, "sec_cfg");
    $display("test done permanent lock");
    results();
  end
  initial begin
    #500000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
